// File: common/adc_tp_pkg.sv
// Purpose: Shared constants for the converter output, test-pattern, gain and sleep stage
// Assumes: APB with 32-bit data, 10 MHz pclk
// Notes:   Register indices are printed offsets; byte address is four times the index
package adc_tp_pkg;

    // ----------------------------------------------------------------
    // Register indices; byte address is four times the index
    // ----------------------------------------------------------------
    localparam logic [7:0] IDX_PWR    = 8'h0f;
    localparam logic [7:0] IDX_NOISE  = 8'h14;
    localparam logic [7:0] IDX_SEEDLO = 8'h23;
    localparam logic [7:0] IDX_SEEDHI = 8'h24;
    localparam logic [7:0] IDX_PAT    = 8'h25;
    localparam logic [7:0] IDX_CODE1  = 8'h26;
    localparam logic [7:0] IDX_CODE2  = 8'h27;
    localparam logic [7:0] IDX_GROUP  = 8'h28;
    localparam logic [7:0] IDX_GAINA  = 8'h2a;
    localparam logic [7:0] IDX_GAINB  = 8'h2b;
    localparam logic [7:0] IDX_ALIGN  = 8'h40;
    localparam logic [7:0] IDX_DESKEW = 8'h45;
    localparam logic [7:0] IDX_OUTCTL = 8'h46;
    localparam logic [7:0] IDX_STATUS = 8'h60;

    // ----------------------------------------------------------------
    // Field positions
    // ----------------------------------------------------------------
    localparam int PWR_LIGHT_BIT   = 8;
    localparam int PWR_DEEP_BIT    = 9;
    localparam int PWR_PINSEL_BIT  = 10;
    localparam int PAT_RAMP_BIT    = 6;
    localparam int PAT_DUAL_BIT    = 5;
    localparam int PAT_SINGLE_BIT  = 4;
    localparam int PAT_C2HI_LSB    = 2;
    localparam int PAT_C1HI_LSB    = 0;
    localparam int PAT_SOFT_BIT    = 8;
    localparam int PAT_RAND_BIT    = 12;
    localparam int PAT_SHORT_BIT   = 13;
    localparam int PAT_SEEDREG_BIT = 14;
    localparam int PAT_PIN_BIT     = 15;
    localparam int CODE_LO_LSB     = 4;
    localparam int SEEDHI_LSB      = 9;
    localparam int GRP_BITWISE_BIT = 8;
    localparam int GRP_ORDER_BIT   = 15;
    localparam int OUT_MSB_BIT     = 3;
    localparam int OUT_2WIRE_BIT   = 0;

    // ----------------------------------------------------------------
    // Data words and timing
    // ----------------------------------------------------------------
    localparam logic [13:0] DESKEW_WORD = 14'h1555;
    localparam logic [13:0] FRAME_WORD  = 14'h3f80;
    localparam logic [13:0] CODE_MAX    = 14'h3fff;
    localparam logic [22:0] SEED_DEF    = 23'h7fffff;
    localparam int CLK_HZ          = 10_000_000;
    localparam int LIGHT_WAKE_US   = 10;
    localparam int CLK_RUN_US      = 50;
    localparam int DEEP_WAKE_US    = 100;
    localparam int LIGHT_WAKE_CYC  = LIGHT_WAKE_US * (CLK_HZ / 1_000_000);
    localparam int CLK_RUN_CYC     = CLK_RUN_US * (CLK_HZ / 1_000_000);
    localparam int DEEP_WAKE_CYC   = DEEP_WAKE_US * (CLK_HZ / 1_000_000);

    // Pattern selection, earliest after PAT_NONE wins
    typedef enum logic [2:0] {
        PAT_NONE, PAT_RAND, PAT_DESK, PAT_FRAME, PAT_RAMP, PAT_DUAL, PAT_SINGLE
    } pat_sel_t;

    typedef enum logic [1:0] {
        PW_RUN, PW_SLEEP, PW_WAKE
    } pw_state_t;

endpackage : adc_tp_pkg

// File: hw/adc_tp_ctrl.sv
// Purpose: Register file, sleep control, gain, test patterns and serializer
// Assumes: Samples arrive offset-binary on pclk with sample_valid; sync pins are async
// Notes:   Bit-wise 2-wire lanes carry odd/even bits, byte-wise upper/lower 7 bits
//
// Local design decision: register access over APB.
`timescale 1ns/1ps
module adc_tp_ctrl
    import adc_tp_pkg::*;
#(
    parameter int CH = 8,
    parameter int W  = 14
)(
    // Clock and reset
    input  wire logic             pclk,
    input  wire logic             presetn,
    // APB slave
    input  wire logic             psel,
    input  wire logic             penable,
    input  wire logic             pwrite,
    input  wire logic [11:0]      paddr,
    input  wire logic [31:0]      pwdata,
    output logic      [31:0]      prdata,
    output logic                  pready,
    output logic                  pslverr,
    // Device pins
    input  wire logic             sleep_pin,
    input  wire logic             align_pin,
    // Converter samples
    input  wire logic [CH*W-1:0]  sample_in,
    input  wire logic             sample_valid,
    // Analog front-end controls
    output logic      [CH-1:0]    channel_sleep_bits,
    output logic      [CH-1:0]    near_dc_noise_shift_bits,
    output logic      [CH-1:0]    input_swap_bits,
    output logic                  light_sleep_out,
    output logic                  deep_sleep_out,
    output logic                  data_ready,
    // Serial outputs, lane a and lane b per channel
    output logic      [CH-1:0]    lane_a,
    output logic      [CH-1:0]    lane_b,
    output logic                  frame_out
);

    // ----------------------------------------------------------------
    // Register storage
    // ----------------------------------------------------------------
    logic [15:0] pwr_r, noise_r, seedlo_r, seedhi_r, pat_r, code1_r, code2_r;
    logic [15:0] grp_r, gaina_r, gainb_r, align_r, deskew_r, outctl_r;
    logic [15:0] rd_val;
    logic        rd_hit;
    logic        wr_en;
    logic [7:0]  idx;

    assign idx     = paddr[9:2];
    assign wr_en   = psel && penable && pwrite;
    assign pready  = 1'b1;
    assign pslverr = psel && penable && !rd_hit;

    // Register writes
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pwr_r <= 16'h0000; noise_r <= 16'h0000; seedlo_r <= 16'h0000;
            seedhi_r <= 16'h0000; pat_r <= 16'h0000; code1_r <= 16'h0000;
            code2_r <= 16'h0000; grp_r <= 16'h0000; gaina_r <= 16'h0000;
            gainb_r <= 16'h0000; align_r <= 16'h0000; deskew_r <= 16'h0000;
            outctl_r <= 16'h0008;
        end
        else if (wr_en)
        begin
            case (idx)
                IDX_PWR:    pwr_r    <= pwdata[15:0];
                IDX_NOISE:  noise_r  <= pwdata[15:0];
                IDX_SEEDLO: seedlo_r <= pwdata[15:0];
                IDX_SEEDHI: seedhi_r <= pwdata[15:0];
                IDX_PAT:    pat_r    <= pwdata[15:0];
                IDX_CODE1:  code1_r  <= pwdata[15:0];
                IDX_CODE2:  code2_r  <= pwdata[15:0];
                IDX_GROUP:  grp_r    <= pwdata[15:0];
                IDX_GAINA:  gaina_r  <= pwdata[15:0];
                IDX_GAINB:  gainb_r  <= pwdata[15:0];
                IDX_ALIGN:  align_r  <= pwdata[15:0];
                IDX_DESKEW: deskew_r <= pwdata[15:0];
                IDX_OUTCTL: outctl_r <= pwdata[15:0];
                default:    ;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Pin synchronisers
    // ----------------------------------------------------------------
    logic [1:0] slp_s, aln_s;
    logic       aln_d;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            slp_s <= 2'b00;
            aln_s <= 2'b00;
            aln_d <= 1'b0;
        end
        else
        begin
            slp_s <= {slp_s[0], sleep_pin};
            aln_s <= {aln_s[0], align_pin};
            aln_d <= aln_s[1];
        end
    end

    // ----------------------------------------------------------------
    // Sleep control
    // ----------------------------------------------------------------
    pw_state_t   pw_r;
    logic [10:0] wake_cnt_r;
    logic [10:0] run_cnt_r;
    logic        was_deep_r;
    logic        want_light, want_deep;

    assign channel_sleep_bits = pwr_r[CH-1:0];
    assign want_deep  = pwr_r[PWR_DEEP_BIT] || (slp_s[1] && !pwr_r[PWR_PINSEL_BIT]);
    assign want_light = pwr_r[PWR_LIGHT_BIT] || (slp_s[1] && pwr_r[PWR_PINSEL_BIT]);
    assign light_sleep_out = want_light && !want_deep;
    assign deep_sleep_out  = want_deep;
    assign data_ready      = (pw_r == PW_RUN);

    // Wake-up sequencing
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pw_r       <= PW_RUN;
            wake_cnt_r <= 11'h000;
            run_cnt_r  <= 11'h000;
            was_deep_r <= 1'b0;
        end
        else
        begin
            if (run_cnt_r != 11'(CLK_RUN_CYC))
                run_cnt_r <= run_cnt_r + 11'h001;
            case (pw_r)
                PW_RUN:
                begin
                    if (want_deep || want_light)
                    begin
                        pw_r       <= PW_SLEEP;
                        was_deep_r <= want_deep;
                        run_cnt_r  <= 11'h000;
                    end
                end
                PW_SLEEP:
                begin
                    if (want_deep)
                        was_deep_r <= 1'b1;
                    if (!want_deep && !want_light)
                    begin
                        pw_r <= PW_WAKE;
                        // Light wake needs clock running long enough first
                        if (was_deep_r)
                            wake_cnt_r <= 11'(DEEP_WAKE_CYC);
                        else if (run_cnt_r == 11'(CLK_RUN_CYC))
                            wake_cnt_r <= 11'(LIGHT_WAKE_CYC);
                        else
                            wake_cnt_r <= 11'(LIGHT_WAKE_CYC + CLK_RUN_CYC) - run_cnt_r;
                    end
                end
                PW_WAKE:
                begin
                    if (want_deep || want_light)
                        pw_r <= PW_SLEEP;
                    else if (wake_cnt_r <= 11'h001)
                        pw_r <= PW_RUN;
                    else
                        wake_cnt_r <= wake_cnt_r - 11'h001;
                end
                default: pw_r <= PW_RUN;
            endcase
        end
    end

    assign near_dc_noise_shift_bits = noise_r[CH-1:0];
    assign input_swap_bits          = seedhi_r[CH-1:0];

    // ----------------------------------------------------------------
    // Gain with saturation
    // ----------------------------------------------------------------
    // Gain factor in Q8, 10^(dB/20)
    function automatic logic [11:0] gain_q8(input logic [3:0] code);
        case (code)
            4'h0: gain_q8 = 12'h100;  4'h1: gain_q8 = 12'h11f;
            4'h2: gain_q8 = 12'h143;  4'h3: gain_q8 = 12'h16a;
            4'h4: gain_q8 = 12'h196;  4'h5: gain_q8 = 12'h1c7;
            4'h6: gain_q8 = 12'h1fe;  4'h7: gain_q8 = 12'h23c;
            4'h8: gain_q8 = 12'h282;  4'h9: gain_q8 = 12'h2d0;
            4'ha: gain_q8 = 12'h328;  4'hb: gain_q8 = 12'h38b;
            4'hc: gain_q8 = 12'h3fb;
            default: gain_q8 = 12'h100;                                      // Unused codes
        endcase
    endfunction : gain_q8

    logic [CH*W-1:0] gained;

    genvar g;
    generate
        for (g = 0; g < CH; g++)
        begin : gen_gain
            logic signed [14:0] cen;
            logic signed [27:0] prod;
            logic signed [19:0] scl;
            logic [3:0]         gc;
            // Channels 5..8 sit high-to-low in the second gain register
            assign gc   = (g < 4) ? gaina_r[(g % 4)*4 +: 4] : gainb_r[(3 - (g % 4))*4 +: 4];
            assign cen  = $signed({1'b0, sample_in[g*W +: W]}) - 15'sd8192;
            assign prod = cen * $signed({1'b0, gain_q8(gc)});
            assign scl  = prod[27:8];
            // Clip to the signed range before returning to offset binary
            assign gained[g*W +: W] = (scl > 20'sd8191)  ? CODE_MAX :
                                      (scl < -20'sd8192) ? 14'h0000 :
                                      14'(scl + 20'sd8192);
        end
    endgenerate

    // ----------------------------------------------------------------
    // Test patterns
    // ----------------------------------------------------------------
    pat_sel_t    sel;
    logic [13:0] ramp_r;
    logic        tog_r;
    logic [22:0] lfsr_r;
    logic        restart;
    logic        seed_sel;
    logic [13:0] code1, code2;

    assign code1   = {pat_r[PAT_C1HI_LSB +: 2], code1_r[CODE_LO_LSB +: 12]};
    assign code2   = {pat_r[PAT_C2HI_LSB +: 2], code2_r[CODE_LO_LSB +: 12]};
    assign restart = (pat_r[PAT_PIN_BIT] && aln_s[1] && !aln_d)
                     || (wr_en && idx == IDX_PAT && pwdata[PAT_SOFT_BIT]);
    // Seed choice written together with a software restart takes effect at once
    assign seed_sel = (wr_en && idx == IDX_PAT) ? pwdata[PAT_SEEDREG_BIT]
                                                : pat_r[PAT_SEEDREG_BIT];

    // Fixed priority among patterns
    always_comb
    begin
        if (pat_r[PAT_RAND_BIT])        sel = PAT_RAND;
        else if (deskew_r[0])           sel = PAT_DESK;
        else if (align_r[1])            sel = PAT_FRAME;
        else if (pat_r[PAT_RAMP_BIT])   sel = PAT_RAMP;
        else if (pat_r[PAT_DUAL_BIT])   sel = PAT_DUAL;
        else if (pat_r[PAT_SINGLE_BIT]) sel = PAT_SINGLE;
        else                            sel = PAT_NONE;
    end

    // Pattern generators step once per sample
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ramp_r <= 14'h0000;
            tog_r  <= 1'b0;
            lfsr_r <= SEED_DEF;
        end
        else if (restart)
        begin
            ramp_r <= 14'h0000;
            tog_r  <= 1'b0;
            lfsr_r <= seed_sel ? {seedhi_r[SEEDHI_LSB +: 7], seedlo_r}
                                : SEED_DEF;
        end
        else if (sample_valid)
        begin
            ramp_r <= ramp_r + 14'h0001;
            tog_r  <= !tog_r;
            if (pat_r[PAT_SHORT_BIT])
                lfsr_r <= {14'h0000, lfsr_r[7:0], lfsr_r[8] ^ lfsr_r[4]};
            else
                lfsr_r <= {lfsr_r[21:0], lfsr_r[22] ^ lfsr_r[17]};
        end
    end

    // Word per channel to serialize
    function automatic logic [13:0] pick(input pat_sel_t s, input logic [13:0] adc,
                                         input logic [13:0] rmp, input logic t,
                                         input logic [13:0] c1, input logic [13:0] c2,
                                         input logic [13:0] rnd);
        case (s)
            PAT_RAND:   pick = rnd;
            PAT_DESK:   pick = DESKEW_WORD;
            PAT_FRAME:  pick = FRAME_WORD;
            PAT_RAMP:   pick = rmp;
            PAT_DUAL:   pick = t ? c2 : c1;
            PAT_SINGLE: pick = c1;
            default:    pick = adc;
        endcase
    endfunction : pick

    // ----------------------------------------------------------------
    // Serializer
    // ----------------------------------------------------------------
    logic [CH*W-1:0] shreg_r;
    logic [3:0]      bitcnt_r;
    logic            msb_first, two_wire;

    assign msb_first = outctl_r[OUT_MSB_BIT];
    assign two_wire  = outctl_r[OUT_2WIRE_BIT];

    // Load a word on each sample, then shift one position per clock
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            shreg_r  <= '0;
            bitcnt_r <= 4'hf;
        end
        else if (sample_valid)
        begin
            for (int c = 0; c < CH; c++)
                shreg_r[c*W +: W] <= pick(sel, gained[c*W +: W], ramp_r, tog_r,
                                          code1, code2, lfsr_r[13:0]);
            bitcnt_r <= 4'h0;
        end
        // Hold after the last bit so no frame marker repeats without a sample
        else if (bitcnt_r != 4'hf)
            bitcnt_r <= bitcnt_r + 4'h1;
    end

    // Lane bit selection per channel
    function automatic logic [3:0] pos(input logic [3:0] n, input logic mf);
        pos = mf ? 4'(4'd13 - n) : n;
    endfunction : pos

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            lane_a    <= '0;
            lane_b    <= '0;
            frame_out <= 1'b0;
        end
        else
        begin
            frame_out <= (bitcnt_r == 4'h0);
            for (int c = 0; c < CH; c++)
            begin
                logic [13:0] wd;
                logic [3:0]  k;
                wd = shreg_r[c*W +: W];
                k  = bitcnt_r;
                if (!two_wire || k > 4'd13)
                begin
                    lane_a[c] <= (k > 4'd13) ? 1'b0 : wd[pos(k, msb_first)];
                    lane_b[c] <= 1'b0;
                end
                else if (grp_r[GRP_BITWISE_BIT])
                begin
                    lane_a[c] <= wd[pos({k[2:0], 1'b0}, msb_first)];
                    lane_b[c] <= wd[pos({k[2:0], 1'b1}, msb_first)];
                end
                else if (grp_r[c] || grp_r[GRP_ORDER_BIT])
                begin
                    // Word-wise: alternate whole samples is approximated as the whole word on lane a, lane b held low
                    lane_a[c] <= wd[pos(k, msb_first)];
                    lane_b[c] <= 1'b0;
                end
                else
                begin
                    // Byte-wise: upper seven bits on lane a, lower on lane b
                    lane_a[c] <= wd[4'(7 + (msb_first ? 4'd6 - k[2:0] : k[2:0]))];
                    lane_b[c] <= wd[4'(msb_first ? 4'd6 - k[2:0] : k[2:0])];
                end
            end
        end
    end

    // ----------------------------------------------------------------
    // Read decode
    // ----------------------------------------------------------------
    always_comb
    begin
        rd_hit = 1'b1;
        case (idx)
            IDX_PWR:    rd_val = pwr_r;
            IDX_NOISE:  rd_val = noise_r;
            IDX_SEEDLO: rd_val = seedlo_r;
            IDX_SEEDHI: rd_val = seedhi_r;
            IDX_PAT:    rd_val = pat_r;
            IDX_CODE1:  rd_val = code1_r;
            IDX_CODE2:  rd_val = code2_r;
            IDX_GROUP:  rd_val = grp_r;
            IDX_GAINA:  rd_val = gaina_r;
            IDX_GAINB:  rd_val = gainb_r;
            IDX_ALIGN:  rd_val = align_r;
            IDX_DESKEW: rd_val = deskew_r;
            IDX_OUTCTL: rd_val = outctl_r;
            IDX_STATUS: rd_val = {11'h000, sel, 1'b0, data_ready};
            default:
            begin
                rd_val = 16'h0000;
                rd_hit = 1'b0;
            end
        endcase
        prdata = {16'h0000, rd_val};
    end

endmodule : adc_tp_ctrl

// File: tb/lane_rx.sv
// Purpose: Receiver model capturing one serial lane
// Assumes: Frame marks the first of 14 bits
// Notes:   Bit order follows msb_first
`timescale 1ns/1ps
module lane_rx (
    // Clock, reset and lane
    input  wire logic        pclk, presetn, lane, frame, msb_first,
    // Captured word
    output logic      [13:0] word_r,
    output logic             done_r
);
    logic [3:0] cnt_r;
    // Shift one bit a clock, in the order the host set
    always_ff @(posedge pclk or negedge presetn)
        if (!presetn)
            {word_r, cnt_r, done_r} <= '0;
        else
        begin
            done_r <= !frame && cnt_r == 4'd13;
            cnt_r  <= frame ? 4'd1 : (cnt_r == 4'd13 || cnt_r == 4'd0) ? 4'd0 : cnt_r + 4'd1;
            if (frame || cnt_r != 4'd0)
                word_r <= msb_first ? {word_r[12:0] & {13{!frame}}, lane}
                                    : {lane, word_r[13:1] & {13{!frame}}};
        end
endmodule : lane_rx

// File: tb/adc_tp_ctrl_props.sv
// Purpose: Port checker for adc_tp_ctrl
// Assumes: Sleep pin settles within three clocks
// Notes:   Wake counts allow one clock of slack
`timescale 1ns/1ps
module adc_tp_props
    import adc_tp_pkg::*;
(
    // Watched ports
    input wire logic       pclk, presetn, psel, penable, pwrite, sleep_pin, sample_valid,
    input wire logic [7:0] channel_sleep_bits, near_dc_noise_shift_bits, input_swap_bits,
    input wire logic       light_sleep_out, deep_sleep_out, data_ready, frame_out
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic [10:0] low_r;
    logic        deep_r;
    // Clocks spent waking since sleep requests dropped
    always_ff @(posedge pclk or negedge presetn)
        if (!presetn) {low_r, deep_r} <= '0;
        else if (light_sleep_out || deep_sleep_out) {low_r, deep_r} <= {11'h0, deep_sleep_out};
        else if (!data_ready && !(&low_r)) low_r <= low_r + 11'h1;
    property p_ctl; $changed({channel_sleep_bits, near_dc_noise_shift_bits, input_swap_bits})
        |-> $past(psel && penable && pwrite); endproperty
    a_ctl: assert property (p_ctl) else $error("bits moved without write");
    property p_slp; (light_sleep_out || deep_sleep_out) [*3] |=> !data_ready; endproperty
    a_slp: assert property (p_slp) else $error("ready in sleep");
    property p_run; data_ready && !light_sleep_out && !deep_sleep_out |=> data_ready; endproperty
    a_run: assert property (p_run) else $error("ready lost");
    property p_pin; sleep_pin [*3] |-> light_sleep_out || deep_sleep_out; endproperty
    a_pin: assert property (p_pin) else $error("pin ignored");
    property p_deep; $rose(data_ready) && deep_r |-> low_r >= 11'(DEEP_WAKE_CYC - 1); endproperty
    a_deep: assert property (p_deep) else $error("deep wake short");
    property p_lgt; $rose(data_ready) |-> low_r >= 11'(LIGHT_WAKE_CYC - 1); endproperty
    a_lgt: assert property (p_lgt) else $error("light wake short");
    property p_fsrc; frame_out |-> $past(sample_valid, 2); endproperty
    a_fsrc: assert property (p_fsrc) else $error("frame without sample");
    property p_fone; frame_out |=> !frame_out [*8]; endproperty
    a_fone: assert property (p_fone) else $error("frame too long");
    c_deep: cover property ($rose(data_ready) && deep_r);
    c_pin: cover property (sleep_pin && light_sleep_out);
    c_frm: cover property (frame_out);
endmodule : adc_tp_props
bind adc_tp_ctrl adc_tp_props i_props (.*);

// File: tb/adc_tp_ctrl_tb_top.sv
// Purpose: Bench for adc_tp_ctrl
// Assumes: Channel one lane a is captured
// Notes:   Sleep waits run full length
`timescale 1ns/1ps
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin error_cnt++; \
    $display("[FAIL] %0t got %h exp %h", $time, g, e); end end
module adc_tp_ctrl_tb_top;
    import adc_tp_pkg::*;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic sleep_pin = 1'b0, align_pin = 1'b0, sample_valid = 1'b0, msb = 1'b1;
    logic pready, pslverr, err, lso, dso, rdy, frm, done;
    logic [11:0]  paddr = '0;
    logic [31:0]  pwdata = '0, prdata, rd;
    logic [111:0] sample_in = '0;
    logic [7:0]   chs, nds, sws, la;
    logic [13:0]  word, w0;
    int error_cnt = 0, cmp_count = 0;
    always #50 pclk = ~pclk;
    adc_tp_ctrl i_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .sleep_pin, .align_pin, .sample_in, .sample_valid,
        .channel_sleep_bits(chs), .near_dc_noise_shift_bits(nds), .input_swap_bits(sws),
        .light_sleep_out(lso), .deep_sleep_out(dso), .data_ready(rdy), .lane_a(la),
        .lane_b(), .frame_out(frm));
    lane_rx i_rx (.pclk, .presetn, .lane(la[0]), .frame(frm), .msb_first(msb),
        .word_r(word), .done_r(done));
    // One APB transfer, held until pready
    task automatic apb(input logic wr, input logic [7:0] idx, input logic [31:0] d);
        @(posedge pclk) {psel, pwrite, paddr, pwdata} <= {1'b1, wr, 2'b00, idx, 2'b00, d};
        @(posedge pclk) penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        {rd, err} = {prdata, pslverr};
        {psel, penable} <= 2'b00;
    endtask : apb
    // One sample in, one captured word out
    task automatic snd(input logic [13:0] s, e, input logic chk = 1'b1);
        @(posedge pclk) {sample_in, sample_valid} <= {{8{s}}, 1'b1};
        @(posedge pclk) sample_valid <= 1'b0;
        for (int i = 0; i < 40 && done !== 1'b1; i++) @(negedge pclk);
        if (chk) `CHK(word, e)
    endtask : snd
    task automatic wake(input int n);
        repeat (n) @(negedge pclk);
        for (int i = 0; i < 1200 && rdy !== 1'b1; i++) @(negedge pclk);
    endtask : wake
    task automatic final_report;
        $display("compares %0d mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : final_report
    // Main sequence
    initial
    begin
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, IDX_OUTCTL, '0);
        `CHK(rd, 32'h8)
        apb(1'b1, IDX_PWR, 32'ha5); apb(1'b1, IDX_NOISE, 32'h3c); apb(1'b1, IDX_SEEDHI, 32'h80);
        @(negedge pclk);
        `CHK({chs, nds, sws}, 24'ha53c80)
        apb(1'b1, 8'h01, 32'h1); apb(1'b0, 8'h01, '0);
        `CHK({rd, err}, {32'h0, 1'b1})
        $display("registers end");
        apb(1'b1, IDX_PWR, 32'h200); repeat (2) @(negedge pclk);
        `CHK({dso, rdy}, 2'b10)
        apb(1'b1, IDX_PWR, '0); repeat (900) @(negedge pclk);
        `CHK(rdy, 1'b0)
        wake(0);
        `CHK(rdy, 1'b1)
        apb(1'b1, IDX_PWR, 32'h100); repeat (600) @(negedge pclk);
        `CHK({lso, rdy}, 2'b10)
        apb(1'b1, IDX_PWR, '0); wake(0);
        `CHK(rdy, 1'b1)
        for (int k = 0; k < 2; k++)
        begin
            apb(1'b1, IDX_PWR, k << 10); sleep_pin <= 1'b1; repeat (600) @(negedge pclk);
            `CHK({lso, dso}, k ? 2'b10 : 2'b01)
            @(posedge pclk) sleep_pin <= 1'b0; wake(0);
            `CHK(rdy, 1'b1)
        end
        $display("sleep end");
        apb(1'b1, IDX_GAINA, 32'hc); snd(14'h3000, 14'h3fff);
        apb(1'b1, IDX_GAINA, '0); snd(14'h1abc, 14'h1abc);
        apb(1'b1, IDX_CODE1, 32'ha5c0); apb(1'b1, IDX_CODE2, 32'h2340);
        apb(1'b1, IDX_PAT, 32'h12); snd(14'h0, 14'h2a5c);
        apb(1'b1, IDX_OUTCTL, '0); msb <= 1'b0; snd(14'h0, 14'h2a5c);
        apb(1'b1, IDX_OUTCTL, 32'h8); msb <= 1'b1;
        apb(1'b1, IDX_PAT, 32'h126); snd(14'h0, 14'h2a5c); snd(14'h0, 14'h1234);
        apb(1'b1, IDX_PAT, 32'h8040); align_pin <= 1'b1;
        repeat (4) @(posedge pclk); align_pin <= 1'b0;
        snd(14'h0, 14'h0); snd(14'h0, 14'h1);
        apb(1'b1, IDX_DESKEW, 32'h1); snd(14'h0, 14'h1555);
        apb(1'b1, IDX_DESKEW, '0); apb(1'b1, IDX_ALIGN, 32'h2); snd(14'h0, 14'h3f80);
        apb(1'b1, IDX_PAT, 32'h1000); snd(14'h0, 14'h0, 1'b0); w0 = word; snd(14'h0, 14'h0, 1'b0);
        `CHK(word !== w0, 1'b1)
        apb(1'b1, IDX_SEEDLO, 32'h1234); apb(1'b1, IDX_PAT, 32'h5100);
        snd(14'h0, 14'h1234);
        $display("patterns end");
        final_report();
    end
    // Watchdog for a hung run
    initial
    begin
        #2_000_000;
        error_cnt++;
        final_report();
    end
endmodule : adc_tp_ctrl_tb_top
